// file: logic/asp_defines.vh
// register map, reset values and axi response codes for the shared analog port block
`ifndef ASP_DEFINES_VH
`define ASP_DEFINES_VH

// register indices as printed; byte address is four times the index
`define ASP_IDX_RSVD_A      16'h0267
`define ASP_IDX_RSVD_B      16'h026b
`define ASP_IDX_RSVD_C      16'h026f
`define ASP_IDX_RSVD_D      16'h0270
`define ASP_IDX_LATCH       16'h0271
`define ASP_IDX_RSVD_E      16'h0272
`define ASP_IDX_DIR         16'h0273
`define ASP_IDX_RSVD_F      16'h0274
`define ASP_IDX_DRIVE       16'h0275
`define ASP_IDX_RSVD_G      16'h0276
`define ASP_IDX_PULLUP      16'h0277
`define ASP_IDX_RSVD_H      16'h0278
`define ASP_IDX_RSVD_LAST   16'h027f

// reset values
`define ASP_RST_LATCH       8'h00
`define ASP_RST_DIR         8'h00
`define ASP_RST_DRIVE       8'h00
`define ASP_RST_PULLUP      8'h00
`define ASP_RSVD_READ       8'h00

// axi response codes
`define ASP_RESP_OKAY       2'b00
`define ASP_RESP_SLVERR     2'b10

`endif

// file: logic/asp_port.v
// gpio logic of an eight-pin port shared with analog converter inputs, axi4-lite slave
`timescale 1ns/1ps
`default_nettype none
`include "asp_defines.vh"

module asp_port (
  // clock, reset, enable
  input  wire        clk,
  input  wire        rst,
  input  wire        clkEn,
  // axi4-lite write address
  input  wire [17:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  // axi4-lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  // axi4-lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // axi4-lite read address
  input  wire [17:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  // axi4-lite read data
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // pins, two-way: output enable low while driving
  input  wire [7:0]  padIn,
  output wire [7:0]  padOut,
  output wire [7:0]  padOutEn_n,
  output wire [7:0]  padReducedDrive,
  output wire [7:0]  padPullupOn,
  // analog converter side
  input  wire [7:0]  converterDigitalInputEnable,
  input  wire [7:0]  converterOwnsPin,
  input  wire [7:0]  altDriveEn,
  input  wire [7:0]  altDriveValue,
  output wire [7:0]  digitalInputLevel
);

  reg  [7:0]  portOutputLatch;
  reg  [7:0]  portDirection;
  reg  [7:0]  portDriveReduce;
  reg  [7:0]  portPullupEnable;
  reg  [7:0]  inSync1;
  reg  [7:0]  inSync2;
  reg  [17:0] awAddr;
  reg         awHeld;
  reg  [31:0] wData;
  reg  [3:0]  wStrb;
  reg         wHeld;
  reg  [7:0]  next_readByte;
  reg         next_readHit;
  wire [7:0]  gatedInput;
  wire [7:0]  dataReadValue;
  wire [7:0]  gpioOwns;
  wire [7:0]  driving;
  wire        doWrite;
  wire        doRead;
  wire [15:0] wrIdx;
  wire [15:0] rdIdx;
  wire        wrLane0;

  // handshakes: one address and one data slot each, held until the write; no new ones taken until the response leaves
  assign s_axi_awready = clkEn & ~awHeld & ~s_axi_bvalid;
  assign s_axi_wready  = clkEn & ~wHeld & ~s_axi_bvalid;
  assign s_axi_arready = clkEn & ~s_axi_rvalid;
  assign doWrite       = clkEn & awHeld & wHeld & ~s_axi_bvalid;
  assign doRead        = s_axi_arvalid & s_axi_arready;
  assign wrIdx         = awAddr[17:2];
  assign rdIdx         = s_axi_araddr[17:2];
  // only the low lane carries the 8-bit register, so only its strobe matters
  assign wrLane0       = wStrb[0];

  // synchroniser; first stage read only by the second
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      inSync1 <= 8'h00;
      inSync2 <= 8'h00;
    end else if (clkEn) begin
      inSync1 <= padIn;
      inSync2 <= inSync1;
    end
  end

  // two-stage sync is why a direction change can take two cycles to show
  assign gatedInput        = inSync2 & converterDigitalInputEnable;
  assign digitalInputLevel = gatedInput;

  // per-pin pad control
  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1) begin : gPin
      assign gpioOwns[i]      = ~converterOwnsPin[i];
      assign driving[i]       = gpioOwns[i] ? portDirection[i] : altDriveEn[i];
      assign padOut[i]        = gpioOwns[i] ? portOutputLatch[i] : altDriveValue[i];
      assign padOutEn_n[i]    = ~driving[i];
      // reduced drive follows the pin whoever drives it
      assign padReducedDrive[i] = driving[i] & portDriveReduce[i];
      assign padPullupOn[i]   = ~driving[i] & portPullupEnable[i];
      assign dataReadValue[i] = portDirection[i] ? portOutputLatch[i]
                                                 : gatedInput[i];
    end
  endgenerate

  // write channel capture, address and data in either order
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      awAddr <= 18'h00000;
      awHeld <= 1'b0;
      wData  <= 32'h00000000;
      wStrb  <= 4'h0;
      wHeld  <= 1'b0;
    end else if (clkEn) begin
      if (s_axi_awvalid && s_axi_awready) begin
        awAddr <= s_axi_awaddr;
        awHeld <= 1'b1;
      end else if (doWrite) begin
        awHeld <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
        wHeld <= 1'b1;
      end else if (doWrite) begin
        wHeld <= 1'b0;
      end
    end
  end

  // register writes; all eight bits land together
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      portOutputLatch  <= `ASP_RST_LATCH;
      portDirection    <= `ASP_RST_DIR;
      portDriveReduce  <= `ASP_RST_DRIVE;
      portPullupEnable <= `ASP_RST_PULLUP;
    end else if (doWrite && wrLane0) begin
      case (wrIdx)
        `ASP_IDX_LATCH:  portOutputLatch  <= wData[7:0];
        `ASP_IDX_DIR:    portDirection    <= wData[7:0];
        `ASP_IDX_DRIVE:  portDriveReduce  <= wData[7:0];
        `ASP_IDX_PULLUP: portPullupEnable <= wData[7:0];
        default:         portOutputLatch  <= portOutputLatch; // reserved writes dropped
      endcase
    end
  end

  // write response
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `ASP_RESP_OKAY;
    end else if (clkEn) begin
      if (doWrite) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= ((wrIdx >= `ASP_IDX_RSVD_A) && (wrIdx <= `ASP_IDX_RSVD_LAST)) ?
                        `ASP_RESP_OKAY : `ASP_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read decode
  always @* begin
    next_readByte = `ASP_RSVD_READ;
    next_readHit  = 1'b1;
    case (rdIdx)
      `ASP_IDX_LATCH:  next_readByte = dataReadValue;
      `ASP_IDX_DIR:    next_readByte = portDirection;
      `ASP_IDX_DRIVE:  next_readByte = portDriveReduce;
      `ASP_IDX_PULLUP: next_readByte = portPullupEnable;
      default: begin
        // reserved slots in the window read zero
        next_readByte = `ASP_RSVD_READ;
        next_readHit  = (rdIdx >= `ASP_IDX_RSVD_A) && (rdIdx <= `ASP_IDX_RSVD_LAST);
      end
    endcase
  end

  // read response, one cycle after the address is taken
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `ASP_RESP_OKAY;
    end else if (clkEn) begin
      if (doRead) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {24'h000000, next_readByte};
        s_axi_rresp  <= next_readHit ? `ASP_RESP_OKAY : `ASP_RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

// file: test/asp_port_asserts.sv
// assertion checker for the shared analog port block
`timescale 1ns/1ps
`default_nettype none
module asp_port_asserts (
  // clock, reset and read handshake
  input wire logic       clk, rst, s_axi_arvalid, s_axi_arready, s_axi_rvalid,
  // pins and converter side
  input wire logic [7:0] padIn, padOut, padOutEn_n, padReducedDrive, padPullupOn,
  input wire logic [7:0] converterDigitalInputEnable, converterOwnsPin, altDriveEn,
  input wire logic [7:0] altDriveValue, digitalInputLevel
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence rdTaken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  chk_drive_input: assert property ((padReducedDrive & padOutEn_n) == 8'h00)
    else $error("reduced drive on input pin");
  chk_pull_output: assert property ((padPullupOn & ~padOutEn_n) == 8'h00)
    else $error("pull-up on output pin");
  chk_din_gate: assert property ((digitalInputLevel & ~converterDigitalInputEnable) == 8'h00)
    else $error("input level passed while disabled");
  // two sync flops: the level lags the pad by exactly two edges
  chk_din_sync: assert property (!$past(rst, 2) && !$past(rst)
    |-> digitalInputLevel == ($past(padIn, 2) & converterDigitalInputEnable))
    else $error("input level not two edges behind pad");
  chk_alt_value: assert property (((padOut ^ altDriveValue) & converterOwnsPin & altDriveEn) == 8'h00)
    else $error("converter value not on pad");
  chk_alt_dir: assert property (((padOutEn_n ^ ~altDriveEn) & converterOwnsPin) == 8'h00)
    else $error("converter enable not on pad");
  chk_reset_input: assert property ($fell(rst) |-> padOutEn_n == 8'hff)
    else $error("pins not inputs after reset");
  chk_read_answer: assert property (rdTaken |=> s_axi_rvalid)
    else $error("read not answered next cycle");
endmodule
`default_nettype wire

// file: test/asp_pin_model.sv
// pad model: resolves each pin from the port, pull-ups and the outside world
`timescale 1ns/1ps
`default_nettype none
module asp_pin_model (
  input wire logic [7:0] padOut, padOutEn_n, padPullupOn, extLevel, extDriven,
  output logic     [7:0] padLevel
);
  // a floating pin without pull-up reads the inverse, so stale values never match
  assign padLevel = ~padOutEn_n & padOut | padOutEn_n & (extDriven & extLevel
                    | ~extDriven & (padPullupOn | ~extLevel));
endmodule
`default_nettype wire

// file: test/testbench.sv
// self-checking bench for the shared analog port block
`timescale 1ns/1ps
`default_nettype none
`include "asp_defines.vh"
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin errors++; \
  $display("[FAIL] %0t got %h want %h", $time, a, b); end end
module testbench;
  logic        clk = 0, rst = 1, clkEn = 1, s_axi_awvalid = 0, s_axi_wvalid = 0;
  logic        s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic [17:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0;
  logic [3:0]  s_axi_wstrb = 4'h1;
  logic [7:0]  converterDigitalInputEnable = 8'hff, converterOwnsPin = 0, altDriveEn = 0;
  logic [7:0]  altDriveValue = 0, extLevel = 0, extDriven = 8'hff;
  wire logic   s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire logic [1:0]  s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata;
  wire logic [7:0]  padIn, padOut, padOutEn_n, padReducedDrive, padPullupOn, digitalInputLevel;
  integer errors = 0, samples_checked = 0;
  logic [1:0]  lastBresp = 2'b11;
  asp_port DUT (.*);
  asp_pin_model pins (.padOut(padOut), .padOutEn_n(padOutEn_n), .padPullupOn(padPullupOn),
    .extLevel(extLevel), .extDriven(extDriven), .padLevel(padIn));
  initial forever #12.5 clk = ~clk;
  task end_sim;
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task tmo(input integer n);
    if (n >= 40) begin
      errors++;
      end_sim;
    end
  endtask
  task wr(input [15:0] i, input [7:0] d);
    logic a, w, b;
    integer n;
    @(posedge clk);
    s_axi_awaddr <= {i, 2'b00};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    n = 0;
    do begin
      @(negedge clk);
      a = s_axi_awready;
      w = s_axi_wready;
      b = s_axi_bvalid;
      if (b) lastBresp = s_axi_bresp;
      @(posedge clk);
      if (a) s_axi_awvalid <= 0;
      if (w) s_axi_wvalid <= 0;
      n++;
    end while (!b && n < 40);
    s_axi_bready <= 0;
    tmo(n);
  endtask
  task rd(input [15:0] i, input [7:0] want, input [1:0] resp);
    logic a, r;
    logic [33:0] got;
    integer n;
    @(posedge clk);
    s_axi_araddr <= {i, 2'b00};
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    n = 0;
    do begin
      @(negedge clk);
      a = s_axi_arready;
      r = s_axi_rvalid;
      got = {s_axi_rresp, s_axi_rdata};
      @(posedge clk);
      if (a) s_axi_arvalid <= 0;
      n++;
    end while (!r && n < 40);
    s_axi_rready <= 0;
    tmo(n);
    `CHK(got, {resp, 24'h0, want})
  endtask
  task t_rsvd;
    logic [15:0] rs [10] = '{`ASP_IDX_RSVD_A, `ASP_IDX_RSVD_B, `ASP_IDX_RSVD_C,
      `ASP_IDX_RSVD_D, `ASP_IDX_RSVD_E, `ASP_IDX_RSVD_F, `ASP_IDX_RSVD_G,
      `ASP_IDX_RSVD_H, 16'h027c, `ASP_IDX_RSVD_LAST};
    `CHK(padOutEn_n, 8'hff)
    rd(`ASP_IDX_DIR, `ASP_RST_DIR, `ASP_RESP_OKAY);
    foreach (rs[k]) begin
      wr(rs[k], 8'hff);
      `CHK(lastBresp, `ASP_RESP_OKAY)
      rd(rs[k], `ASP_RSVD_READ, `ASP_RESP_OKAY);
    end
    rd(16'h0280, 8'h00, `ASP_RESP_SLVERR);
    wr(16'h0280, 8'hff);
    `CHK(lastBresp, `ASP_RESP_SLVERR)
    $display("reserved test done");
  endtask
  task t_out;
    wr(`ASP_IDX_DIR, 8'hff);
    wr(`ASP_IDX_LATCH, 8'ha5);
    wr(`ASP_IDX_DRIVE, 8'h0f);
    wr(`ASP_IDX_PULLUP, 8'hff);
    `CHK({padOutEn_n, padOut}, 16'h00a5)
    `CHK({padReducedDrive, padPullupOn}, 16'h0f00)
    rd(`ASP_IDX_LATCH, 8'ha5, `ASP_RESP_OKAY);
    rd(`ASP_IDX_PULLUP, 8'hff, `ASP_RESP_OKAY);
    $display("output test done");
  endtask
  task t_in;
    extLevel <= 8'h3c;
    wr(`ASP_IDX_DIR, 8'h00);
    repeat (3) @(posedge clk);
    rd(`ASP_IDX_LATCH, 8'h3c, `ASP_RESP_OKAY);
    converterDigitalInputEnable <= 8'h0f;
    extDriven <= 8'h00;
    wr(`ASP_IDX_PULLUP, 8'hf0);
    // floating pins: pulled ones read high, the rest read inverse of the old level
    repeat (3) @(posedge clk);
    @(negedge clk);
    `CHK({digitalInputLevel, padPullupOn, padReducedDrive}, 24'h03f000)
    @(posedge clk);
    converterDigitalInputEnable <= 8'hff;
    repeat (3) @(posedge clk);
    rd(`ASP_IDX_LATCH, 8'hf3, `ASP_RESP_OKAY);
    extDriven <= 8'hff;
    extLevel <= 8'h00;
    $display("input test done");
  endtask
  task t_mix;
    wr(`ASP_IDX_DIR, 8'h0f);
    repeat (2) @(posedge clk);
    rd(`ASP_IDX_LATCH, 8'h05, `ASP_RESP_OKAY);
    wr(`ASP_IDX_DIR, 8'hf0);
    converterOwnsPin <= 8'hf0;
    altDriveEn <= 8'h30;
    altDriveValue <= 8'ha0;
    wr(`ASP_IDX_DRIVE, 8'hff);
    `CHK({padOutEn_n, padReducedDrive, padOut & 8'h30}, 24'hcf3020)
    rd(`ASP_IDX_LATCH, 8'ha0, `ASP_RESP_OKAY);
    $display("direction and converter test done");
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst <= 0;
    t_rsvd;
    t_out;
    t_in;
    t_mix;
    end_sim;
  end
endmodule
bind asp_port asp_port_asserts chk (.*);
`default_nettype wire
